/* rtl/ssp_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
// ==========================================
// register offsets
`define SSP_OFF_BUF 8'h00
`define SSP_OFF_CON1 8'h04
`define SSP_OFF_CON3 8'h08
`define SSP_OFF_STAT 8'h0C
`define SSP_OFF_IRQ 8'h10
// ==========================================
// field positions
`define SSP_CON1_WRITE_COLLISION_FLAG 7
`define SSP_CON1_OVF 6
`define SSP_CON1_EN 5
`define SSP_CON1_CKP 4
`define SSP_CON3_BUFFER_OVERWRITE_ENABLE 4
`define SSP_STAT_SMP 7
`define SSP_STAT_CKE 6
`define SSP_STAT_BF 0
`define SSP_IRQ_FLAG 0
`define SSP_IRQ_EN 1
// ==========================================
// mode codes and reset values
`define SSP_MODE_SLV_SS 4'h4
`define SSP_MODE_SLV_NOSS 4'h5
`define SSP_MODE_RST 4'h0
`define SSP_BYTE_RST 8'h00
// ==========================================
// timing
`define SSP_CLK_NS 10
`define SSP_SCK_PERIOD_NS 160
`define SSP_HOST_HALF ((`SSP_SCK_PERIOD_NS + 2 * `SSP_CLK_NS - 1) / (2 * `SSP_CLK_NS))
`define SSP_MST_HALF0 7'h02
`define SSP_MST_HALF1 7'h08
`define SSP_MST_HALF2 7'h20
`define SSP_MST_HALF3 7'h40
`endif

/* rtl/ssp_pkg.sv */
// shared types of the serial port
package ssp_pkg;
    typedef logic [7:0] ssp_addr_t;
    typedef logic [31:0] ssp_word_t;
    typedef logic [7:0] ssp_byte_t;
    typedef enum logic [2:0] {hs_idle, hs_setup, hs_run, hs_hold, hs_gap} ssp_host_state_t;
endpackage

/* rtl/ssp_link_if.sv */
// serial link between the port and an external master
`timescale 1ns/10ps
interface ssp_link_if;
    logic host_sck;
    logic dev_sck;
    logic dev_sck_oe;
    logic ss_n;
    logic m2s_data;
    logic s2m_data;
    logic s2m_oe;
    logic sck;
    logic s2m;
    // ==========================================
    // wire resolution; undriven data line floats high via pull-up
    assign sck = dev_sck_oe ? dev_sck : host_sck;
    assign s2m = s2m_oe ? s2m_data : 1'b1;
    modport dev (input sck, input ss_n, input m2s_data,
        output dev_sck, output dev_sck_oe, output s2m_data, output s2m_oe);
    modport host (input s2m, output host_sck, output ss_n, output m2s_data);
endinterface

/* rtl/ssp_port_dev.sv */
// synchronous serial port, slave end with register access over apb
// ==========================================
// Overview of operation
// - slave shifts only on external master clock
// - clock line idle before slave enabled
// - master supplies clock; slave never drives it
// - slave shifting independent of device sleep
// - received byte raises interrupt, wakes device
// - overwrite enable accepts writes despite unread
// - mode 0100 selects slave with select
// - select low enables shifting, drives output
// - select high floats output immediately; here three pclk cycles later, after the synchroniser
// - select high resets serial logic
// - serial reset clears bit counter
// - master frames each transfer with select
// - edge select set requires select control
// - sample phase bit kept clear in slave
// - master mode freezes during sleep
// - full byte copied, buffer full, interrupt
// - write while busy ignored, collision flagged
// - reading buffer clears buffer full
// - shifting most significant bit first
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "ssp_defs.svh"
module ssp_port_dev (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire ssp_pkg::ssp_addr_t paddr,
    input wire ssp_pkg::ssp_word_t pwdata,
    output ssp_pkg::ssp_word_t prdata,
    output logic pready,
    output logic pslverr,
    // power
    input wire logic sleep_req,
    output logic irq,
    output logic wake,
    // link
    ssp_link_if.dev link
);
    import ssp_pkg::*;

    function automatic logic addr_ok(input ssp_addr_t a);
        addr_ok = (a == `SSP_OFF_BUF) || (a == `SSP_OFF_CON1) || (a == `SSP_OFF_CON3)
            || (a == `SSP_OFF_STAT) || (a == `SSP_OFF_IRQ);
    endfunction

    function automatic logic [6:0] mst_half(input logic [1:0] m);
        case (m)
            2'h0: mst_half = `SSP_MST_HALF0;
            2'h1: mst_half = `SSP_MST_HALF1;
            2'h2: mst_half = `SSP_MST_HALF2;
            default: mst_half = `SSP_MST_HALF3;
        endcase
    endfunction

    logic write_collision_flag_reg, ovf_reg, en_reg, ckp_reg, buffer_overwrite_enable_reg, smp_reg, cke_reg;
    logic bf_reg, irqf_reg, irqen_reg;
    logic [3:0] mode_reg;
    ssp_byte_t buf_reg, sr_reg;
    logic [2:0] cnt_reg;
    logic out_reg, sck_prev_reg, m_sck_reg, m_run_reg;
    logic [6:0] div_reg;
    logic [3:0] tog_reg;
    logic [2:0] s1_reg, s2_reg, s3_reg, hold_reg;
    logic [2:0] filt;
    ssp_word_t rd_data;

    // ==========================================
    // pin synchronisers (sck, select, data in)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 3'h7;
            s2_reg <= 3'h7;
            s3_reg <= 3'h7;
            hold_reg <= 3'h7;
        end else begin
            s1_reg <= {link.m2s_data, link.ss_n, link.sck};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            hold_reg <= filt;
        end
    end

    // a change counts once stages two and three agree
    generate
        for (genvar i = 0; i < 3; i++) begin : g_filt
            assign filt[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : hold_reg[i];
        end
    endgenerate

    // ==========================================
    // mode decode
    logic is_slave, is_master, ss_ctl, sel_high, serial_rst, tick, lead, trail;
    logic shift_ok, s_edge, d_edge, byte_done, sdi;
    assign ss_ctl = (mode_reg == `SSP_MODE_SLV_SS);
    assign is_slave = ss_ctl || (mode_reg == `SSP_MODE_SLV_NOSS);
    assign is_master = (mode_reg[3:2] == 2'h0);
    assign sel_high = ss_ctl && filt[1];
    assign serial_rst = !en_reg || sel_high;
    assign sdi = filt[2];
    assign tick = m_run_reg && !sleep_req && (div_reg == mst_half(mode_reg[1:0]) - 7'h01);
    // edges come from the external clock in slave mode, from tick in master mode
    assign lead = is_master ? (tick && m_sck_reg == ckp_reg)
        : (filt[0] != ckp_reg && sck_prev_reg == ckp_reg);
    assign trail = is_master ? (tick && m_sck_reg != ckp_reg)
        : (filt[0] == ckp_reg && sck_prev_reg != ckp_reg);
    assign shift_ok = en_reg && (is_master || (is_slave && !sel_high));
    // sample phase bit has no effect in slave
    assign s_edge = shift_ok && (cke_reg ? lead : trail);
    assign d_edge = shift_ok && (cke_reg ? trail : lead);
    assign byte_done = s_edge && (cnt_reg == 3'h7);

    // ==========================================
    // apb access
    logic wr, rd, buf_wr, buf_rd, busy, wr_accept;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign buf_wr = wr && (paddr == `SSP_OFF_BUF);
    assign buf_rd = rd && (paddr == `SSP_OFF_BUF);
    assign busy = (cnt_reg != 3'h0) || m_run_reg;
    // overwrite enable lifts the unread block
    assign wr_accept = buf_wr && !busy && !write_collision_flag_reg && (buffer_overwrite_enable_reg || !bf_reg);

    always_comb begin
        rd_data = 32'h0000_0000;
        if (paddr == `SSP_OFF_BUF) begin
            rd_data[7:0] = buf_reg;
        end else if (paddr == `SSP_OFF_CON1) begin
            rd_data[7:0] = {write_collision_flag_reg, ovf_reg, en_reg, ckp_reg, mode_reg};
        end else if (paddr == `SSP_OFF_CON3) begin
            rd_data[`SSP_CON3_BUFFER_OVERWRITE_ENABLE] = buffer_overwrite_enable_reg;
        end else if (paddr == `SSP_OFF_STAT) begin
            rd_data[`SSP_STAT_SMP] = smp_reg;
            rd_data[`SSP_STAT_CKE] = cke_reg;
            rd_data[`SSP_STAT_BF] = bf_reg;
        end else if (paddr == `SSP_OFF_IRQ) begin
            rd_data[`SSP_IRQ_FLAG] = irqf_reg;
            rd_data[`SSP_IRQ_EN] = irqen_reg;
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_data;
        end
    end

    // ==========================================
    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 1'b0;
            ckp_reg <= 1'b0;
            mode_reg <= `SSP_MODE_RST;
            buffer_overwrite_enable_reg <= 1'b0;
            smp_reg <= 1'b0;
            cke_reg <= 1'b0;
            irqen_reg <= 1'b0;
        end else if (wr) begin
            if (paddr == `SSP_OFF_CON1) begin
                en_reg <= pwdata[`SSP_CON1_EN];
                ckp_reg <= pwdata[`SSP_CON1_CKP];
                mode_reg <= pwdata[3:0];
            end else if (paddr == `SSP_OFF_CON3) begin
                buffer_overwrite_enable_reg <= pwdata[`SSP_CON3_BUFFER_OVERWRITE_ENABLE];
            end else if (paddr == `SSP_OFF_STAT) begin
                smp_reg <= pwdata[`SSP_STAT_SMP];
                cke_reg <= pwdata[`SSP_STAT_CKE];
            end else if (paddr == `SSP_OFF_IRQ) begin
                irqen_reg <= pwdata[`SSP_IRQ_EN];
            end
        end
    end

    // ==========================================
    // status flags; a hardware set beats a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_collision_flag_reg <= 1'b0;
            ovf_reg <= 1'b0;
            bf_reg <= 1'b0;
            irqf_reg <= 1'b0;
        end else begin
            if (buf_wr && !wr_accept) begin
                write_collision_flag_reg <= 1'b1;
            end else if (wr && paddr == `SSP_OFF_CON1 && !pwdata[`SSP_CON1_WRITE_COLLISION_FLAG]) begin
                write_collision_flag_reg <= 1'b0;
            end
            if (byte_done && bf_reg && !buffer_overwrite_enable_reg) begin
                ovf_reg <= 1'b1;
            end else if (wr && paddr == `SSP_OFF_CON1 && !pwdata[`SSP_CON1_OVF]) begin
                ovf_reg <= 1'b0;
            end
            if (byte_done) begin
                bf_reg <= 1'b1;
            end else if (buf_rd) begin
                bf_reg <= 1'b0;
            end
            // byte end flags even in sleep
            if (byte_done) begin
                irqf_reg <= 1'b1;
            end else if (wr && paddr == `SSP_OFF_IRQ && pwdata[`SSP_IRQ_FLAG]) begin
                irqf_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // shift engine; runs regardless of sleep in slave mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_reg <= `SSP_BYTE_RST;
            cnt_reg <= 3'h0;
            out_reg <= 1'b0;
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= filt[0];
            // select high drops a partial byte
            if (serial_rst) begin
                cnt_reg <= 3'h0;
            end else if (s_edge) begin
                cnt_reg <= cnt_reg + 3'h1;
            end
            // msb leaves first, new bit enters lsb
            if (wr_accept) begin
                sr_reg <= pwdata[7:0];
            end else if (s_edge) begin
                // shift follows the link clock in slave mode, tick in master mode
                sr_reg <= {sr_reg[6:0], sdi};
            end
            if (wr_accept) begin
                out_reg <= pwdata[7];
            end else if (d_edge) begin
                out_reg <= sr_reg[7];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_reg <= `SSP_BYTE_RST;
        end else if (wr_accept) begin
            buf_reg <= pwdata[7:0];
        end else if (byte_done && (buffer_overwrite_enable_reg || !bf_reg)) begin
            buf_reg <= {sr_reg[6:0], sdi};
        end
    end

    // ==========================================
    // master clock generator; holds its phase while asleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_run_reg <= 1'b0;
            m_sck_reg <= 1'b0;
            div_reg <= 7'h00;
            tog_reg <= 4'h0;
        end else if (!en_reg || !is_master) begin
            m_run_reg <= 1'b0;
            m_sck_reg <= ckp_reg;
            div_reg <= 7'h00;
            tog_reg <= 4'h0;
        end else if (wr_accept) begin
            m_run_reg <= 1'b1;
        end else if (tick) begin
            div_reg <= 7'h00;
            m_sck_reg <= !m_sck_reg;
            tog_reg <= tog_reg + 4'h1;
            if (tog_reg == 4'hF) begin
                m_run_reg <= 1'b0;
            end
        end else if (m_run_reg && !sleep_req) begin
            div_reg <= div_reg + 7'h01;
        end else if (!m_run_reg) begin
            m_sck_reg <= ckp_reg;
        end
    end

    // ==========================================
    // link drive and interrupt
    // clock driven only in master mode
    assign link.dev_sck_oe = en_reg && is_master;
    assign link.dev_sck = m_sck_reg;
    // output released once the synchronised select is high
    assign link.s2m_oe = shift_ok;
    assign link.s2m_data = out_reg;
    assign irq = irqf_reg && irqen_reg;
    assign wake = irq && sleep_req;
endmodule

/* rtl/ssp_spi_host.sv */
// external spi master end: frames one byte per request
`timescale 1ns/10ps
`include "ssp_defs.svh"
module ssp_spi_host (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input wire logic cfg_clock_idle_polarity,
    input wire logic cfg_clock_edge_select,
    // request and answer
    input wire logic xfer_start,
    input wire ssp_pkg::ssp_byte_t tx_byte,
    output ssp_pkg::ssp_byte_t rx_byte,
    output logic rx_valid,
    output logic busy,
    // link
    ssp_link_if.host link
);
    import ssp_pkg::*;

    localparam logic [4:0] HALF = 5'(`SSP_HOST_HALF);

    ssp_host_state_t state_reg;
    logic [4:0] div_reg;
    logic [3:0] tog_reg;
    logic sck_reg, ss_reg, m2s_reg;
    ssp_byte_t hsr_reg;
    logic s1_reg, s2_reg, s3_reg, hold_reg, sdi;
    logic tick, lead, trail;

    // ==========================================
    // data-in synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            hold_reg <= 1'b1;
        end else begin
            s1_reg <= link.s2m;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            hold_reg <= sdi;
        end
    end
    assign sdi = (s2_reg == s3_reg) ? s3_reg : hold_reg;

    assign tick = (state_reg != hs_idle) && (div_reg == HALF - 5'h01);
    assign lead = tick && (state_reg == hs_run) && (sck_reg == cfg_clock_idle_polarity);
    assign trail = tick && (state_reg == hs_run) && (sck_reg != cfg_clock_idle_polarity);

    // ==========================================
    // frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= hs_idle;
            div_reg <= 5'h00;
            tog_reg <= 4'h0;
            sck_reg <= 1'b0;
            ss_reg <= 1'b1;
            m2s_reg <= 1'b0;
            hsr_reg <= `SSP_BYTE_RST;
            rx_byte <= `SSP_BYTE_RST;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            div_reg <= tick ? 5'h00 : div_reg + 5'h01;
            if (lead || trail) begin
                sck_reg <= !sck_reg;
                tog_reg <= tog_reg + 4'h1;
            end
            if (cfg_clock_edge_select ? lead : trail) begin
                hsr_reg <= {hsr_reg[6:0], sdi};
            end
            if (cfg_clock_edge_select ? trail : lead) begin
                m2s_reg <= hsr_reg[7];
            end
            case (state_reg)
                hs_idle: begin
                    sck_reg <= cfg_clock_idle_polarity;
                    div_reg <= 5'h00;
                    // select falls to open each frame
                    if (xfer_start) begin
                        ss_reg <= 1'b0;
                        hsr_reg <= tx_byte;
                        m2s_reg <= tx_byte[7];
                        tog_reg <= 4'h0;
                        state_reg <= hs_setup;
                    end
                end
                hs_setup: begin
                    if (tick) begin
                        state_reg <= hs_run;
                    end
                end
                hs_run: begin
                    if (tick && tog_reg == 4'hF) begin
                        state_reg <= hs_hold;
                    end
                end
                hs_hold: begin
                    if (tick) begin
                        ss_reg <= 1'b1;
                        rx_byte <= hsr_reg;
                        rx_valid <= 1'b1;
                        state_reg <= hs_gap;
                    end
                end
                default: begin
                    if (tick) begin
                        state_reg <= hs_idle;
                    end
                end
            endcase
        end
    end

    // the link clock is made here
    assign link.host_sck = sck_reg;
    assign link.ss_n = ss_reg;
    assign link.m2s_data = m2s_reg;
    assign busy = (state_reg != hs_idle);
endmodule

/* sim/ssp_link_chk.sv */
// link checker: frame shape and data-line drive between the two ends
`timescale 1ns/10ps
// ==========================================
// checker
module ssp_link_chk (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // link
    input wire logic host_sck,
    input wire logic dev_sck_oe,
    input wire logic ss_n,
    input wire logic s2m_oe
);
    logic [7:0] edge_cnt_reg;
    logic sck_q_reg;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // clock toggles per frame; cleared while deselected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_cnt_reg <= 8'h00;
            sck_q_reg <= 1'b0;
        end else begin
            sck_q_reg <= host_sck;
            if (ss_n)
                edge_cnt_reg <= 8'h00;
            else if (host_sck != sck_q_reg)
                edge_cnt_reg <= edge_cnt_reg + 8'h01;
        end
    end
    // ==========================================
    // assertions
    // device never clocks
    AST_NO_DEV_CLK: assert property (!dev_sck_oe)
        else $error("device drove the serial clock");
    AST_SEL_DRIVES: assert property (!ss_n [*6] |-> s2m_oe)
        else $error("data out not driven while selected");
    AST_DESEL_FLOATS: assert property ($rose(ss_n) |-> ##[1:5] !s2m_oe)
        else $error("data out still driven after deselect");
    AST_STAYS_FLOAT: assert property (ss_n [*6] |-> !s2m_oe)
        else $error("data out driven while deselected");
    AST_SETUP_QUIET: assert property ($fell(ss_n) |-> $stable(host_sck) [*7])
        else $error("clock moved during select setup");
    AST_SIXTEEN_EDGES: assert property ($rose(ss_n) |-> edge_cnt_reg == 8'h10)
        else $error("frame did not carry sixteen clock edges");
    AST_SEL_MIN: assert property ($fell(ss_n) |-> !ss_n [*8])
        else $error("select pulse too short");
    AST_FRAME_END: assert property ($fell(ss_n) |-> ##[131:170] $rose(ss_n))
        else $error("frame length out of range");
    AST_GAP: assert property ($rose(ss_n) |-> ss_n [*8])
        else $error("gap between frames too short");
    // ==========================================
    // covers
    cover property ($fell(ss_n));
    cover property ($rose(s2m_oe));
    cover property ($rose(ss_n) ##[9:40] $fell(ss_n));
endmodule

/* sim/testbench.sv */
// self-checking bench: apb port end joined to the spi master end
`timescale 1ns/10ps
`include "ssp_defs.svh"
module testbench;
    import ssp_pkg::*;
    // ==========================================
    // signals
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    ssp_addr_t paddr;
    ssp_word_t pwdata;
    ssp_word_t prdata;
    logic pready;
    logic pslverr;
    logic sleep_req;
    logic irq;
    logic wake;
    logic cpol;
    logic cke;
    logic xfer_start;
    ssp_byte_t tx_byte;
    ssp_byte_t rx_byte;
    logic rx_valid;
    logic busy;
    ssp_word_t rd_data;
    logic rd_err;
    logic [1:0] cfg;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    ssp_byte_t host_tx [4] = '{8'h3C, 8'h81, 8'hC3, 8'h7E};
    ssp_byte_t dev_tx [4] = '{8'hA5, 8'h5A, 8'h96, 8'h01};
    ssp_link_if link_if ();
    // ==========================================
    // design ends and checker
    ssp_port_dev ssp_port_dev_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .irq(irq), .wake(wake),
        .link(link_if.dev));
    ssp_spi_host ssp_spi_host_inst (.pclk(pclk), .presetn(presetn),
        .cfg_clock_idle_polarity(cpol), .cfg_clock_edge_select(cke), .xfer_start(xfer_start),
        .tx_byte(tx_byte), .rx_byte(rx_byte), .rx_valid(rx_valid), .busy(busy),
        .link(link_if.host));
    ssp_link_chk ssp_link_chk_inst (.pclk(pclk), .presetn(presetn),
        .host_sck(link_if.host_sck), .dev_sck_oe(link_if.dev_sck_oe), .ss_n(link_if.ss_n),
        .s2m_oe(link_if.s2m_oe));
    // ==========================================
    // clock and hang guard; a run needs about 1600 cycles
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            close_out();
        end
    end
    // ==========================================
    // tasks
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input ssp_word_t seen, input ssp_word_t exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input ssp_addr_t addr, input ssp_word_t data);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no local bound: only the bench's cycle ceiling ends a hung wait
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input ssp_addr_t addr, input ssp_word_t exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(what, rd_data, exp);
    endtask
    // one byte each way; a local count of 400 cycles bounds the waits
    task automatic frame(input ssp_byte_t tx, input ssp_byte_t exp);
        int n = 0;
        @(posedge pclk);
        xfer_start <= 1'b1;
        tx_byte <= tx;
        @(posedge pclk);
        xfer_start <= 1'b0;
        while (rx_valid !== 1'b1 && n < 400) begin
            n = n + 1;
            @(posedge pclk);
        end
        check("master rx byte", {24'h0, rx_byte}, {24'h0, exp});
        while (busy !== 1'b0 && n < 400) begin
            n = n + 1;
            @(posedge pclk);
        end
    endtask
    // ==========================================
    // tests
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        sleep_req = 1'b0;
        cpol = 1'b0;
        cke = 1'b0;
        xfer_start = 1'b0;
        tx_byte = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("control one reset", `SSP_OFF_CON1, 32'h0000_0000);
        rd_chk("status reset", `SSP_OFF_STAT, 32'h0000_0000);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped read", rd_data, 32'h0000_0000);
        check("unmapped error", {31'h0, rd_err}, 32'h0000_0001);
        $display("test reset and map done");
        // every clock polarity and edge choice; the last one asleep
        for (int i = 0; i < 4; i++) begin
            cfg = 2'(i);
            apb(1'b1, `SSP_OFF_CON1, {27'h0, cfg[0], `SSP_MODE_SLV_SS});
            cpol <= cfg[0];
            cke <= cfg[1];
            apb(1'b1, `SSP_OFF_STAT, {25'h0, cfg[1], 6'h00});
            apb(1'b1, `SSP_OFF_CON1, {26'h0, 1'b1, cfg[0], `SSP_MODE_SLV_SS});
            apb(1'b1, `SSP_OFF_IRQ, 32'h0000_0002);
            apb(1'b1, `SSP_OFF_BUF, {24'h0, dev_tx[i]});
            sleep_req <= (i == 3);
            frame(host_tx[i], dev_tx[i]);
            check("irq out", {31'h0, irq}, 32'h0000_0001);
            check("wake out", {31'h0, wake}, {31'h0, i == 3});
            rd_chk("status full", `SSP_OFF_STAT, {25'h0, cfg[1], 6'h01});
            rd_chk("irq flag", `SSP_OFF_IRQ, 32'h0000_0003);
            rd_chk("rx buffer", `SSP_OFF_BUF, {24'h0, host_tx[i]});
            rd_chk("status read", `SSP_OFF_STAT, {25'h0, cfg[1], 6'h00});
            apb(1'b1, `SSP_OFF_IRQ, 32'h0000_0003);
            sleep_req <= 1'b0;
            @(posedge pclk);
            check("irq cleared", {31'h0, irq}, 32'h0000_0000);
            $display("test exchange %0d done", i);
        end
        // unread byte: refused without overwrite, accepted with it
        frame(8'h44, 8'h7E);
        apb(1'b1, `SSP_OFF_BUF, 32'h0000_0011);
        rd_chk("full collision", `SSP_OFF_CON1, 32'h0000_00B4);
        apb(1'b1, `SSP_OFF_CON1, 32'h0000_0034);
        apb(1'b1, `SSP_OFF_CON3, 32'h0000_0010);
        apb(1'b1, `SSP_OFF_BUF, 32'h0000_0022);
        rd_chk("overwrite ok", `SSP_OFF_CON1, 32'h0000_0034);
        frame(8'h99, 8'h22);
        rd_chk("overwritten", `SSP_OFF_BUF, 32'h0000_0099);
        $display("test overwrite done");
        // write in mid-byte is dropped and blocks later writes
        fork
            frame(8'h5B, 8'h99);
            begin
                repeat (60) @(posedge pclk);
                apb(1'b1, `SSP_OFF_BUF, 32'h0000_0066);
                rd_chk("busy collision", `SSP_OFF_CON1, 32'h0000_00B4);
            end
        join
        apb(1'b1, `SSP_OFF_BUF, 32'h0000_0066);
        apb(1'b1, `SSP_OFF_CON1, 32'h0000_0034);
        frame(8'h00, 8'h5B);
        $display("test collision done");
        // unread byte without overwrite: buffer kept, overflow flagged
        apb(1'b1, `SSP_OFF_CON3, 32'h0000_0000);
        frame(8'h12, 8'h00);
        rd_chk("overflow flag", `SSP_OFF_CON1, 32'h0000_0074);
        rd_chk("unread kept", `SSP_OFF_BUF, 32'h0000_0000);
        $display("test overflow done");
        close_out();
    end
endmodule
